// [display_power_mode_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - signal status reports data enable on bit 2, bits 1 and 0 read zero
// - command 0Fh returns two bytes; second holds diag bits 7,6, rest zero
// - diag bit 7 toggles when register loading completes correctly
// - diag bit 6 toggles when display functionality check passes
// - sleep entry 10h stops converter, oscillator and panel scanning
// - command interface and status readback keep working while asleep
// - sleep entry while already asleep is ignored
// - only sleep exit 11h leaves the sleep state
// - sleep entry completes within 120 ms
// - sleep exit 11h enables converter, oscillator and panel scanning
// - sleep exit while already awake is ignored
// - only sleep entry 10h or soft reset leaves the awake state
// - defaults are reloaded during the 5 ms after sleep exit
// - self diagnostics run during the 5 ms after sleep exit
// - sleep exit completes within 120 ms
// - 12h enters partial mode, only 13h or soft reset returns to normal mode
// - partial on while already partial is ignored
// - status reads return a dummy byte first, then the status byte
module display_power_mode_ctrl import display_cmd_pkg::*; #(
   parameter int CYCLES_PER_MS = CYCLES_PER_MS_DEF
) (
   // clock and reset
   input wire logic clk_sys_in,
   input wire logic arst_n_in,
   input wire logic soft_reset_in,
   // host command interface
   input wire logic data_command_select_in,
   input wire logic write_strobe_n_in,
   input wire logic read_strobe_n_in,
   input wire logic [7:0] host_data_in,
   output logic [7:0] host_data_out,
   output logic host_data_oe_out,
   // display status inputs
   input wire logic pixel_data_enable_in,
   input wire logic [4:0] signal_flags_in,
   input wire logic reg_load_ok_in,
   input wire logic display_check_ok_in,
   // power and mode outputs
   output power_ctrl_t power_ctrl_out,
   output logic partial_mode_out,
   output logic asleep_out
);

   // ************************************************************
   // strobe edges and millisecond tick
   // ************************************************************
   logic write_rise;
   logic read_rise;
   logic ms_tick;
   logic tick_restart;
   ctrl_state_t st;
   ctrl_state_t next_st;

   strobe_edge u_write_edge (
      .clk_sys_in(clk_sys_in),
      .arst_n_in(arst_n_in),
      .level_in(write_strobe_n_in),
      .rise_out(write_rise)
   );

   strobe_edge u_read_edge (
      .clk_sys_in(clk_sys_in),
      .arst_n_in(arst_n_in),
      .level_in(read_strobe_n_in),
      .rise_out(read_rise)
   );

   tick_divider #(
      .DIV(CYCLES_PER_MS)
   ) u_ms_tick (
      .clk_sys_in(clk_sys_in),
      .arst_n_in(arst_n_in),
      .restart_in(tick_restart),
      .tick_out(ms_tick)
   );

   // ************************************************************
   // command decode
   // ************************************************************
   logic cmd_valid;
   logic sleep_entry_cmd;
   logic sleep_exit_cmd;
   logic partial_on_cmd;
   logic normal_display_cmd;
   logic read_signal_mode_cmd;
   logic read_self_diag_cmd;
   logic param_read;

   // commands are written with select low, parameters read with select high
   assign cmd_valid = write_rise & ~data_command_select_in;
   assign param_read = read_rise & data_command_select_in;
   assign sleep_entry_cmd = cmd_valid & (host_data_in == CMD_SLEEP_ENTRY);
   assign sleep_exit_cmd = cmd_valid & (host_data_in == CMD_SLEEP_EXIT);
   assign partial_on_cmd = cmd_valid & (host_data_in == CMD_PARTIAL_ON);
   assign normal_display_cmd = cmd_valid & (host_data_in == CMD_NORMAL_DISPLAY);
   assign read_signal_mode_cmd = cmd_valid & (host_data_in == CMD_READ_SIGNAL_MODE);
   assign read_self_diag_cmd = cmd_valid & (host_data_in == CMD_READ_SELF_DIAG);

   assign tick_restart = (sleep_entry_cmd & (st.pwr == PWR_AWAKE))
      | (sleep_exit_cmd & (st.pwr == PWR_ASLEEP));

   // ************************************************************
   // next state
   // ************************************************************
   always_comb begin
      next_st = st;
      next_st.sig_status = {signal_flags_in, pixel_data_enable_in, 2'b00};

      unique case (st.pwr)
         PWR_AWAKE: begin
            // sleep exit here falls through unchanged
            if (sleep_entry_cmd) begin
               next_st.pwr = PWR_ENTERING;
               next_st.ms_cnt = '0;
               next_st.pctl.scan_en = 1'b0;
            end
         end
         PWR_ENTERING: begin
            if (ms_tick) begin
               next_st.ms_cnt = st.ms_cnt + MS_CNT_W'(1);
            end
            if (ms_tick && st.ms_cnt == SLEEP_SETTLE_CNT - MS_CNT_W'(1)) begin
               next_st.pwr = PWR_ASLEEP;
               next_st.pctl.dcdc_en = 1'b0;
               next_st.pctl.osc_en = 1'b0;
            end
         end
         PWR_ASLEEP: begin
            // sleep entry here falls through unchanged
            if (sleep_exit_cmd) begin
               next_st.pwr = PWR_EXITING;
               next_st.ms_cnt = '0;
               next_st.pctl.dcdc_en = 1'b1;
               next_st.pctl.osc_en = 1'b1;
               next_st.pctl.reload = 1'b1;
               next_st.pctl.self_test = 1'b1;
            end
         end
         PWR_EXITING: begin
            if (ms_tick) begin
               next_st.ms_cnt = st.ms_cnt + MS_CNT_W'(1);
            end
            if (ms_tick && st.ms_cnt == WAKE_SETTLE_CNT - MS_CNT_W'(1)) begin
               next_st.pwr = PWR_AWAKE;
               next_st.pctl.scan_en = 1'b1;
               next_st.pctl.reload = 1'b0;
               next_st.pctl.self_test = 1'b0;
               next_st.diag[1] = st.diag[1] ^ reg_load_ok_in;
               next_st.diag[0] = st.diag[0] ^ display_check_ok_in;
            end
         end
      endcase

      if (partial_on_cmd) begin
         next_st.partial = 1'b1;
      end else if (normal_display_cmd) begin
         next_st.partial = 1'b0;
      end

      // readback is served in every power state
      if (read_signal_mode_cmd) begin
         next_st.rd_sel = RD_SIGNAL;
         next_st.param_idx = PARAM_DUMMY;
      end else if (read_self_diag_cmd) begin
         next_st.rd_sel = RD_DIAG;
         next_st.param_idx = PARAM_DUMMY;
      end else if (cmd_valid) begin
         next_st.rd_sel = RD_NONE;
      end else if (param_read && st.param_idx != PARAM_DONE) begin
         next_st.param_idx = st.param_idx + 2'h1;
      end

      next_st.data_oe = ~read_strobe_n_in & data_command_select_in;
      next_st.data_out = DUMMY_BYTE;
      if (st.param_idx == PARAM_STATUS) begin
         unique case (st.rd_sel)
            RD_SIGNAL: next_st.data_out = st.sig_status;
            RD_DIAG: next_st.data_out = {st.diag, 6'h00};
            default: next_st.data_out = DUMMY_BYTE;
         endcase
      end

      if (soft_reset_in) begin
         next_st.pwr = PWR_ASLEEP;
         next_st.ms_cnt = '0;
         next_st.partial = 1'b0;
         next_st.diag = SELF_DIAG_RESET;
         next_st.rd_sel = RD_NONE;
         next_st.param_idx = PARAM_DUMMY;
         next_st.pctl = '0;
      end

      // registered copy of the sleep decode keeps the pin straight from a flop
      next_st.asleep = (next_st.pwr == PWR_ASLEEP);
   end

   // ************************************************************
   // state register
   // ************************************************************
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         st.pwr <= PWR_ASLEEP;
         st.ms_cnt <= '0;
         st.partial <= 1'b0;
         st.diag <= SELF_DIAG_RESET;
         st.sig_status <= SIGNAL_STATUS_RESET;
         st.rd_sel <= RD_NONE;
         st.param_idx <= PARAM_DUMMY;
         st.data_out <= DUMMY_BYTE;
         st.data_oe <= 1'b0;
         st.pctl <= '0;
         st.asleep <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   assign host_data_out = st.data_out;
   assign host_data_oe_out = st.data_oe;
   assign power_ctrl_out = st.pctl;
   assign partial_mode_out = st.partial;
   assign asleep_out = st.asleep;

   // ************************************************************
   // checks
   // ************************************************************
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!arst_n_in);

   a_de_flag_low_bits: assert property (
      $past(arst_n_in) |-> st.sig_status[SIG_DE_BIT] == $past(pixel_data_enable_in)
      && st.sig_status[1:0] == 2'b00)
      else $error("signal status does not track data enable");

   a_diag_zero_bits: assert property (
      st.param_idx == PARAM_STATUS && st.rd_sel == RD_DIAG && !soft_reset_in
      |=> host_data_out[5:0] == 6'h00 && host_data_out[7:6] == $past(st.diag))
      else $error("diag status byte wrong");

   a_dummy_first: assert property (
      (read_signal_mode_cmd || read_self_diag_cmd) && !soft_reset_in
      |=> st.param_idx == PARAM_DUMMY ##1 host_data_out == DUMMY_BYTE)
      else $error("first parameter is not the dummy byte");

   a_diag_toggle: assert property (
      st.pwr == PWR_EXITING && next_st.pwr == PWR_AWAKE && !soft_reset_in
      |=> st.diag == ($past(st.diag) ^ {$past(reg_load_ok_in), $past(display_check_ok_in)}))
      else $error("diag bits did not toggle on check result");

   a_sleep_power_off: assert property (
      st.pwr == PWR_ASLEEP |-> !power_ctrl_out.dcdc_en && !power_ctrl_out.osc_en
      && !power_ctrl_out.scan_en)
      else $error("power still on while asleep");

   a_asleep_holds: assert property (
      st.pwr == PWR_ASLEEP && !sleep_exit_cmd |=> st.pwr == PWR_ASLEEP)
      else $error("left sleep without sleep exit");

   a_awake_holds: assert property (
      st.pwr == PWR_AWAKE && !sleep_entry_cmd && !soft_reset_in |=> st.pwr == PWR_AWAKE)
      else $error("left awake state without sleep entry");

   a_exit_powers_up: assert property (
      st.pwr == PWR_ASLEEP && sleep_exit_cmd && !soft_reset_in
      |=> power_ctrl_out.dcdc_en && power_ctrl_out.osc_en && power_ctrl_out.reload
      && power_ctrl_out.self_test)
      else $error("sleep exit did not start supplies and checks");

   a_settle_bound: assert property (
      (st.pwr == PWR_ENTERING || st.pwr == PWR_EXITING) |-> st.ms_cnt < SLEEP_SETTLE_CNT
      && st.ms_cnt < MS_CNT_W'(MODE_SWITCH_MAX_MS))
      else $error("power transition overran its window");

   a_read_while_asleep: assert property (
      st.pwr == PWR_ASLEEP && !read_strobe_n_in && data_command_select_in |=> host_data_oe_out)
      else $error("readback not served while asleep");

   a_partial_mode: assert property (
      partial_on_cmd && !soft_reset_in |=> partial_mode_out ##1 partial_mode_out || $past(
      normal_display_cmd) || $past(soft_reset_in))
      else $error("partial mode not entered or lost");

   a_soft_reset_state: assert property (
      soft_reset_in |=> asleep_out && !partial_mode_out && power_ctrl_out == '0)
      else $error("soft reset did not return to sleep and normal mode");

   a_status_second: assert property (
      st.param_idx == PARAM_STATUS && st.rd_sel == RD_SIGNAL
      |=> host_data_out == $past(st.sig_status))
      else $error("second parameter is not the signal status");

   a_entry_scan_off: assert property (
      st.pwr == PWR_AWAKE && sleep_entry_cmd && !soft_reset_in
      |=> st.pwr == PWR_ENTERING && !power_ctrl_out.scan_en && !asleep_out)
      else $error("sleep entry did not stop panel scanning");

endmodule // display_power_mode_ctrl
`default_nettype wire

// [display_cmd_pkg.sv]
package display_cmd_pkg;

   // ************************************************************
   // command codes
   // ************************************************************
   localparam logic [7:0] CMD_READ_SIGNAL_MODE = 8'h0E;
   localparam logic [7:0] CMD_READ_SELF_DIAG = 8'h0F;
   localparam logic [7:0] CMD_SLEEP_ENTRY = 8'h10;
   localparam logic [7:0] CMD_SLEEP_EXIT = 8'h11;
   localparam logic [7:0] CMD_PARTIAL_ON = 8'h12;
   localparam logic [7:0] CMD_NORMAL_DISPLAY = 8'h13;

   // ************************************************************
   // timing
   // ************************************************************
   localparam int CLK_HZ = 25_000_000;
   localparam int CYCLES_PER_MS_DEF = CLK_HZ / 1000;
   localparam int SLEEP_SETTLE_MS = 5;
   localparam int WAKE_SETTLE_MS = 5;
   localparam int MODE_SWITCH_MAX_MS = 120;
   localparam int MS_CNT_W = 7;
   localparam logic [MS_CNT_W-1:0] SLEEP_SETTLE_CNT = MS_CNT_W'(SLEEP_SETTLE_MS);
   localparam logic [MS_CNT_W-1:0] WAKE_SETTLE_CNT = MS_CNT_W'(WAKE_SETTLE_MS);

   // ************************************************************
   // status bytes: reset values and field positions
   // ************************************************************
   localparam logic [7:0] SIGNAL_STATUS_RESET = 8'h00;
   localparam logic [1:0] SELF_DIAG_RESET = 2'h0;
   localparam logic [7:0] DUMMY_BYTE = 8'h00;
   localparam int SIG_FLAGS_LSB = 3;
   localparam int SIG_DE_BIT = 2;
   localparam int DIAG_LOAD_BIT = 7;
   localparam int DIAG_FUNC_BIT = 6;
   localparam logic [1:0] PARAM_DUMMY = 2'h0;
   localparam logic [1:0] PARAM_STATUS = 2'h1;
   localparam logic [1:0] PARAM_DONE = 2'h2;

   // ************************************************************
   // types
   // ************************************************************
   typedef enum logic [1:0] {PWR_ASLEEP, PWR_ENTERING, PWR_EXITING, PWR_AWAKE} power_state_t;
   typedef enum logic [1:0] {RD_NONE, RD_SIGNAL, RD_DIAG} read_sel_t;

   typedef struct packed {
      logic dcdc_en;
      logic osc_en;
      logic scan_en;
      logic reload;
      logic self_test;
   } power_ctrl_t;

   typedef struct packed {
      power_state_t pwr;
      logic [MS_CNT_W-1:0] ms_cnt;
      logic partial;
      logic [1:0] diag;
      logic [7:0] sig_status;
      read_sel_t rd_sel;
      logic [1:0] param_idx;
      logic [7:0] data_out;
      logic data_oe;
      power_ctrl_t pctl;
      logic asleep;
   } ctrl_state_t;

endpackage

// [strobe_edge.sv]
`timescale 1ns/1ps
`default_nettype none
module strobe_edge (
   // clock and reset
   input wire logic clk_sys_in,
   input wire logic arst_n_in,
   // strobe
   input wire logic level_in,
   output logic rise_out
);
   logic last;

   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         last <= 1'b1;
      end else begin
         last <= level_in;
      end
   end

   assign rise_out = level_in & ~last;
endmodule // strobe_edge
`default_nettype wire

// [tick_divider.sv]
`timescale 1ns/1ps
`default_nettype none
module tick_divider #(
   parameter int DIV = 25000
) (
   // clock and reset
   input wire logic clk_sys_in,
   input wire logic arst_n_in,
   // control
   input wire logic restart_in,
   output logic tick_out
);
   localparam int W = $clog2(DIV + 1);
   localparam logic [W-1:0] LAST = W'(DIV - 1);
   logic [W-1:0] count;

   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         count <= '0;
         tick_out <= 1'b0;
      end else if (restart_in) begin
         count <= '0;
         tick_out <= 1'b0;
      end else begin
         tick_out <= (count == LAST);
         count <= (count == LAST) ? '0 : count + W'(1);
      end
   end
endmodule // tick_divider
`default_nettype wire

// [host_cmd_model.sv]
`timescale 1ns/1ps
`default_nettype none
module host_cmd_model import display_cmd_pkg::*; #(
   parameter int CYCLES_PER_MS = 10,
   parameter real PERIOD_NS = 40.0
) (
   // clock
   input wire logic clk_sys_in,
   // host bus
   output logic select_out,
   output logic write_n_out,
   output logic read_n_out,
   output logic [7:0] data_out,
   input wire logic [7:0] data_in,
   input wire logic data_oe_in
);
   localparam real MS_NS = CYCLES_PER_MS * PERIOD_NS;
   realtime last_slp = -1.0e9;
   logic [7:0] last_code = 8'h00;

   initial begin
      select_out = 1'b1;
      write_n_out = 1'b1;
      read_n_out = 1'b1;
      data_out = 8'h00;
   end

   // ************************************************************
   // command write, holding off while supplies settle
   // ************************************************************
   task automatic write_cmd(input logic [7:0] code);
      logic slp;
      slp = (code == CMD_SLEEP_ENTRY) || (code == CMD_SLEEP_EXIT);
      while ($realtime - last_slp < 5.0 * MS_NS) @(posedge clk_sys_in);
      if (slp && code != last_code) begin
         while ($realtime - last_slp < 120.0 * MS_NS) @(posedge clk_sys_in);
      end
      @(posedge clk_sys_in);
      select_out <= 1'b0;
      data_out <= code;
      write_n_out <= 1'b0;
      @(posedge clk_sys_in);
      write_n_out <= 1'b1;
      @(posedge clk_sys_in);
      // bus released: show the inverse so stale data cannot pass
      data_out <= ~code;
      if (slp) begin
         last_slp = $realtime;
         last_code = code;
      end
   endtask

   // ************************************************************
   // parameter read
   // ************************************************************
   task automatic read_param(output logic [7:0] value, output logic oe);
      @(posedge clk_sys_in);
      select_out <= 1'b1;
      read_n_out <= 1'b0;
      repeat (3) @(posedge clk_sys_in);
      #1;
      value = data_in;
      oe = data_oe_in;
      @(posedge clk_sys_in);
      read_n_out <= 1'b1;
      repeat (3) @(posedge clk_sys_in);
   endtask

   // first byte is a dummy, second the status
   task automatic read_status(input logic [7:0] code, output logic [7:0] dummy,
                              output logic [7:0] status, output logic oe);
      write_cmd(code);
      read_param(dummy, oe);
      read_param(status, oe);
   endtask
endmodule // host_cmd_model
`default_nettype wire

// [display_power_mode_ctrl_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module display_power_mode_ctrl_bench import display_cmd_pkg::*;;
   localparam int CPM = 10;
   logic clk_sys_in = 1'b0;
   logic arst_n_in = 1'b0;
   logic soft_reset_in = 1'b0;
   logic sel;
   logic wr_n;
   logic rd_n;
   logic [7:0] hdata_in;
   logic [7:0] hdata_out;
   logic hoe;
   logic pde = 1'b0;
   logic [4:0] flags = 5'h00;
   logic load_ok = 1'b0;
   logic check_ok = 1'b0;
   power_ctrl_t pctl;
   logic partial;
   logic asleep;
   int bad_count = 0;
   int compares = 0;

   always #20 clk_sys_in = ~clk_sys_in;

   display_power_mode_ctrl #(.CYCLES_PER_MS(CPM)) DUT (
      .clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .soft_reset_in(soft_reset_in),
      .data_command_select_in(sel), .write_strobe_n_in(wr_n), .read_strobe_n_in(rd_n),
      .host_data_in(hdata_in), .host_data_out(hdata_out), .host_data_oe_out(hoe),
      .pixel_data_enable_in(pde), .signal_flags_in(flags), .reg_load_ok_in(load_ok),
      .display_check_ok_in(check_ok), .power_ctrl_out(pctl), .partial_mode_out(partial),
      .asleep_out(asleep));

   host_cmd_model #(.CYCLES_PER_MS(CPM), .PERIOD_NS(40.0)) host (
      .clk_sys_in(clk_sys_in), .select_out(sel), .write_n_out(wr_n), .read_n_out(rd_n),
      .data_out(hdata_in), .data_in(hdata_out), .data_oe_in(hoe));

   // ************************************************************
   // helpers
   // ************************************************************
   task automatic stop_test();
      $display("checks made %0d, mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
      compares++;
      if (seen !== exp) begin
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
         bad_count++;
      end
   endtask

   task automatic check_state(input logic [4:0] exp_pctl, input logic exp_sleep,
                              input logic exp_part);
      check("power_ctrl", {3'h0, exp_pctl}, {3'h0, pctl});
      check("asleep", {7'h00, exp_sleep}, {7'h00, asleep});
      check("partial", {7'h00, exp_part}, {7'h00, partial});
   endtask

   task automatic read_check(input logic [7:0] code, input logic [7:0] exp);
      logic [7:0] d;
      logic [7:0] s;
      logic oe;
      host.read_status(code, d, s, oe);
      check("dummy byte", 8'h00, d);
      check("status byte", exp, s);
      check("drive enable", 8'h01, {7'h00, oe});
   endtask

   task automatic cmd_edge(input logic [7:0] code);
      host.write_cmd(code);
      @(posedge clk_sys_in);
      #1;
   endtask

   // ************************************************************
   // scenarios
   // ************************************************************
   task automatic test_signal();
      @(posedge clk_sys_in);
      pde <= 1'b1;
      flags <= 5'h0A;
      repeat (2) @(posedge clk_sys_in);
      read_check(CMD_READ_SIGNAL_MODE, 8'h54);
      pde <= 1'b0;
      flags <= 5'h15;
      repeat (2) @(posedge clk_sys_in);
      read_check(CMD_READ_SIGNAL_MODE, 8'hA8);
      $display("test signal_status done");
   endtask

   task automatic test_wake();
      load_ok <= 1'b1;
      check_ok <= 1'b0;
      cmd_edge(CMD_SLEEP_EXIT);
      check_state(5'h1B, 1'b0, 1'b0);
      repeat (5 * CPM + 4) @(posedge clk_sys_in);
      #1;
      check_state(5'h1C, 1'b0, 1'b0);
      read_check(CMD_READ_SELF_DIAG, 8'h80);
      cmd_edge(CMD_SLEEP_EXIT);
      check_state(5'h1C, 1'b0, 1'b0);
      read_check(CMD_READ_SELF_DIAG, 8'h80);
      $display("test wake done");
   endtask

   task automatic test_partial();
      logic [7:0] codes [4] = '{CMD_PARTIAL_ON, CMD_PARTIAL_ON, CMD_NORMAL_DISPLAY,
                                CMD_NORMAL_DISPLAY};
      logic exp [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
      for (int i = 0; i < 4; i++) begin
         cmd_edge(codes[i]);
         check_state(5'h1C, 1'b0, exp[i]);
      end
      $display("test partial done");
   endtask

   task automatic test_sleep();
      cmd_edge(CMD_SLEEP_ENTRY);
      check_state(5'h18, 1'b0, 1'b0);
      repeat (5 * CPM + 4) @(posedge clk_sys_in);
      #1;
      check_state(5'h00, 1'b1, 1'b0);
      cmd_edge(CMD_SLEEP_ENTRY);
      check_state(5'h00, 1'b1, 1'b0);
      read_check(CMD_READ_SELF_DIAG, 8'h80);
      $display("test sleep done");
   endtask

   task automatic test_soft();
      check_ok <= 1'b1;
      cmd_edge(CMD_SLEEP_EXIT);
      repeat (5 * CPM + 4) @(posedge clk_sys_in);
      read_check(CMD_READ_SELF_DIAG, 8'h40);
      cmd_edge(CMD_PARTIAL_ON);
      check_state(5'h1C, 1'b0, 1'b1);
      @(posedge clk_sys_in);
      soft_reset_in <= 1'b1;
      @(posedge clk_sys_in);
      soft_reset_in <= 1'b0;
      @(posedge clk_sys_in);
      #1;
      check_state(5'h00, 1'b1, 1'b0);
      read_check(CMD_READ_SELF_DIAG, 8'h00);
      cmd_edge(CMD_PARTIAL_ON);
      check_state(5'h00, 1'b1, 1'b1);
      $display("test soft_reset done");
   endtask

   // ************************************************************
   // main sequence and watchdog
   // ************************************************************
   initial begin
      repeat (5) @(posedge clk_sys_in);
      arst_n_in <= 1'b1;
      repeat (2) @(posedge clk_sys_in);
      #1;
      check_state(5'h00, 1'b1, 1'b0);
      test_signal();
      test_wake();
      test_partial();
      test_sleep();
      test_soft();
      stop_test();
   end

   initial begin
      repeat (12000) @(posedge clk_sys_in);
      bad_count++;
      $display("[FAIL] watchdog expected finish seen timeout");
      stop_test();
   end
endmodule // display_power_mode_ctrl_bench
`default_nettype wire
